// *** rtl/rpg_consts.svh ***
`ifndef RPG_CONSTS_SVH
`define RPG_CONSTS_SVH

// ==========================================================================
// Register indices. The printed offsets are not all multiples of four, so
// each one is kept as an index and its byte address is four times that.
// ==========================================================================
`define RPG_IDX_RECEIVE_PORT_CONTROL 8'h0C
`define RPG_IDX_IO_SUPPLY_CONTROL    8'h0D
`define RPG_IDX_PIN_LEVEL_READBACK   8'h0E
`define RPG_IDX_PIN_INPUT_ENABLES    8'h0F
`define RPG_IDX_PIN0_OUTPUT_CONTROL  8'h10

// ==========================================================================
// Field positions.
// ==========================================================================
`define RPG_LINK_MAP_MSB      7
`define RPG_LINK_MAP_LSB      4
`define RPG_RX_ENABLE_MSB     3
`define RPG_RX_ENABLE_LSB     0
`define RPG_HV_SELECT_BIT     7
`define RPG_OVERRIDE_BIT      6
`define RPG_SUPPLY_MODE_MSB   5
`define RPG_SUPPLY_MODE_LSB   4

// ==========================================================================
// Reset values and fixed read values.
// ==========================================================================
`define RPG_RST_LINK_MAP       4'h0
`define RPG_RST_RX_ENABLE      4'hF
`define RPG_RST_HV_SELECT      1'b0
`define RPG_RST_OVERRIDE       1'b0
`define RPG_RST_SUPPLY_MODE    2'h0
`define RPG_IO_RESERVED_VALUE  4'h9
`define RPG_RST_PIN_LEVELS     8'h00
`define RPG_RST_INPUT_ENABLES  8'hFF
`define RPG_RST_PIN0_CONTROL   8'h00
`define RPG_MODE_1V8           2'h0
`define RPG_MODE_3V3           2'h3

// ==========================================================================
// Bus answers.
// ==========================================================================
`define RPG_RESP_OKAY    2'h0
`define RPG_RESP_DECERR  2'h3
`define RPG_READ_ZERO    32'h0000_0000

`endif

// *** rtl/rpg_pkg.sv ***
// ==========================================================================
// Types shared by the register slice and its users.
// ==========================================================================
package rpg_pkg;

   // Receiver enables and back-channel link routing.
   typedef struct packed {
      logic [3:0] link_target_port_select; // Bit n routes link n to port 1.
      logic [3:0] receiver_enable;         // Bit n enables receiver n.
   } rpg_rx_ctl_type;

   // Applied I/O supply controls.
   typedef struct packed {
      logic       high_voltage_io_select;  // 1 selects the 3.3V supply.
      logic [1:0] supply_mode;             // 00 is 1.8V, 11 is 3.3V.
   } rpg_io_supply_control_type;

endpackage

// *** rtl/rpg_sync.sv ***
`timescale 1ns/1ps

// ==========================================================================
// Two-flop synchroniser for the pin levels and the detected supply level.
// ==========================================================================
module rpg_sync (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Asynchronous levels in.
   input  wire logic [8:0] async_in,
   // Synchronised levels out.
   output logic      [8:0] sync_out
);

   logic [8:0] first_stage; // Read only by the second stage.

   // The first stage may go metastable; only the second stage looks at it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         first_stage <= 9'h000;
         sync_out    <= 9'h000;
      end else begin
         first_stage <= async_in;
         sync_out    <= first_stage;
      end
   end

endmodule

// *** rtl/rpg_regs.sv ***
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rpg_consts.svh"

// Overview of operation
// [RQ1] Bits 7:4 route each link to port 0/1.
// [RQ2] Bits 3:0 enable receivers, reset enabled.
// [RQ3] Bit 7 selects 1.8V or 3.3V I/O.
// [RQ4] Override clear: detected level drives both controls.
// [RQ5] Override set: written values drive both controls.
// [RQ6] Mode 00 1.8V, 11 3.3V; reads show detection. The code reads back the written values while the override is set.
// [RQ7] Read-only register shows eight pin levels.
// [RQ8] Eight input enables, one per pin, reset on.

// ==========================================================================
// Receive port, I/O supply and pin register slice on AXI4-Lite.
// ==========================================================================
module rpg_regs (
   // Clock and reset.
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   // AXI4-Lite write address channel.
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Pins and detected supply level, asynchronous.
   input  wire logic [7:0]             gpio_pin_level,
   input  wire logic                   io_voltage_detect,
   // Controls applied to the rest of the device.
   output rpg_pkg::rpg_rx_ctl_type     rx_ctl,
   output rpg_pkg::rpg_io_supply_control_type     io_supply_control,
   output logic [7:0]                  pin_input_enables,
   output logic [7:0]                  pin0_output_control
);
   import rpg_pkg::*;

   // ======================================================================
   // Storage.
   // ======================================================================
   logic [3:0] link_target_port_select; // Link routing bits.
   logic [3:0] receiver_enable;         // Receiver enable bits.
   logic       sw_high_voltage_select;  // Written voltage select.
   logic       supply_level_override;   // Override of detection.
   logic [1:0] sw_supply_mode;          // Written supply mode.
   logic [7:0] pin_level_bits;          // Sampled pin levels.
   logic [7:0] input_enable;            // Per-pin input enables.
   logic [7:0] pin0_control;            // Pin 0 output control byte.
   logic [8:0] synced;                  // Synchronised pins and detection.
   logic       detected_3v3;            // Detected supply is 3.3V.
   logic       applied_select;          // Voltage select in effect.
   logic [1:0] applied_mode;            // Supply mode in effect.

   // Write channel holding state.
   logic       aw_held;                 // Write address accepted.
   logic       w_held;                  // Write data accepted.
   logic [7:0] aw_addr;                 // Held write address.
   logic [7:0] w_data;                  // Held low byte of write data.
   logic       w_lane0;                 // Held strobe of byte lane 0.

   // ======================================================================
   // Address decode shared by the read and write paths.
   // ======================================================================
   // Returns 1 when the byte address is word aligned and hits the index.
   function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] idx);
      logic [9:0] byte_addr;
      byte_addr = {idx, 2'b00};
      addr_hits = ({2'b00, addr} == byte_addr);
   endfunction

   // Returns 1 when the byte address hits any register of the slice.
   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = addr_hits(addr, `RPG_IDX_RECEIVE_PORT_CONTROL)
                  | addr_hits(addr, `RPG_IDX_IO_SUPPLY_CONTROL)
                  | addr_hits(addr, `RPG_IDX_PIN_LEVEL_READBACK)
                  | addr_hits(addr, `RPG_IDX_PIN_INPUT_ENABLES)
                  | addr_hits(addr, `RPG_IDX_PIN0_OUTPUT_CONTROL);
   endfunction

   // ======================================================================
   // Pin and detection synchronisers.
   // ======================================================================
   rpg_sync u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({io_voltage_detect, gpio_pin_level}),
      .sync_out (synced)
   );

   assign detected_3v3 = synced[8];

   // ======================================================================
   // Supply control selection.
   // ======================================================================
   // Detection wins unless software has set the override.
   always_comb begin
      if (supply_level_override) begin
         applied_select = sw_high_voltage_select; // RQ5
         applied_mode   = sw_supply_mode;         // RQ5
      end else begin
         applied_select = detected_3v3;           // RQ4
         applied_mode   = detected_3v3 ? `RPG_MODE_3V3 : `RPG_MODE_1V8; // RQ6
      end
   end

   // ======================================================================
   // Write channel.
   // ======================================================================
   // Each channel is ready while its own item is not yet held and no write answer is pending.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   // Capture the write address and data in either order.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (aw_held && w_held) begin
         // The write is performed this edge; release both holders.
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // Raise the write response once both halves are held.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RPG_RESP_OKAY;
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(aw_addr) ? `RPG_RESP_OKAY : `RPG_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ======================================================================
   // Register updates.
   // ======================================================================
   // Receive port control: routing and enables, written in lane 0.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         link_target_port_select <= `RPG_RST_LINK_MAP;
         receiver_enable         <= `RPG_RST_RX_ENABLE;
      end else if (aw_held && w_held && w_lane0
                   && addr_hits(aw_addr, `RPG_IDX_RECEIVE_PORT_CONTROL)) begin
         link_target_port_select <= w_data[`RPG_LINK_MAP_MSB:`RPG_LINK_MAP_LSB];   // RQ1
         receiver_enable         <= w_data[`RPG_RX_ENABLE_MSB:`RPG_RX_ENABLE_LSB]; // RQ2
      end
   end

   // I/O supply control: written values are kept even while not applied.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sw_high_voltage_select <= `RPG_RST_HV_SELECT;
         supply_level_override  <= `RPG_RST_OVERRIDE;
         sw_supply_mode         <= `RPG_RST_SUPPLY_MODE;
      end else if (aw_held && w_held && w_lane0
                   && addr_hits(aw_addr, `RPG_IDX_IO_SUPPLY_CONTROL)) begin
         sw_high_voltage_select <= w_data[`RPG_HV_SELECT_BIT];                       // RQ3
         supply_level_override  <= w_data[`RPG_OVERRIDE_BIT];                        // RQ5
         sw_supply_mode         <= w_data[`RPG_SUPPLY_MODE_MSB:`RPG_SUPPLY_MODE_LSB]; // RQ6
      end
   end

   // Per-pin input enables.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input_enable <= `RPG_RST_INPUT_ENABLES;
      end else if (aw_held && w_held && w_lane0
                   && addr_hits(aw_addr, `RPG_IDX_PIN_INPUT_ENABLES)) begin
         input_enable <= w_data; // RQ8
      end
   end

   // Pin 0 output control byte, stored whole for the output mux downstream.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin0_control <= `RPG_RST_PIN0_CONTROL;
      end else if (aw_held && w_held && w_lane0
                   && addr_hits(aw_addr, `RPG_IDX_PIN0_OUTPUT_CONTROL)) begin
         pin0_control <= w_data;
      end
   end

   // Pin levels are sampled every cycle; a disabled input reads as low.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_level_bits <= `RPG_RST_PIN_LEVELS;
      end else begin
         pin_level_bits <= synced[7:0] & input_enable; // RQ7 RQ8
      end
   end

   // ======================================================================
   // Read channel.
   // ======================================================================
   // One read at a time; a new address is taken once the data is gone.
   assign s_axi_arready = !s_axi_rvalid;

   // Form the read data at the edge that takes the address.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= `RPG_READ_ZERO;
         s_axi_rresp  <= `RPG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= addr_mapped(s_axi_araddr) ? `RPG_RESP_OKAY : `RPG_RESP_DECERR;
         if (addr_hits(s_axi_araddr, `RPG_IDX_RECEIVE_PORT_CONTROL)) begin
            s_axi_rdata <= {24'h00_0000, link_target_port_select, receiver_enable};
         end else if (addr_hits(s_axi_araddr, `RPG_IDX_IO_SUPPLY_CONTROL)) begin
            // Reads show the applied level, detected unless overridden.
            s_axi_rdata <= {24'h00_0000, applied_select, supply_level_override,
                            applied_mode, `RPG_IO_RESERVED_VALUE}; // RQ6
         end else if (addr_hits(s_axi_araddr, `RPG_IDX_PIN_LEVEL_READBACK)) begin
            s_axi_rdata <= {24'h00_0000, pin_level_bits}; // RQ7
         end else if (addr_hits(s_axi_araddr, `RPG_IDX_PIN_INPUT_ENABLES)) begin
            s_axi_rdata <= {24'h00_0000, input_enable};
         end else if (addr_hits(s_axi_araddr, `RPG_IDX_PIN0_OUTPUT_CONTROL)) begin
            s_axi_rdata <= {24'h00_0000, pin0_control};
         end else begin
            // Unmapped addresses read as zero with a decode error.
            s_axi_rdata <= `RPG_READ_ZERO;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ======================================================================
   // Control outputs, all from flip-flops.
   // ======================================================================
   // Applied supply controls are registered so the pads see clean levels.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         io_supply_control <= '{`RPG_RST_HV_SELECT, `RPG_RST_SUPPLY_MODE};
      end else begin
         io_supply_control <= '{applied_select, applied_mode}; // RQ3 RQ4 RQ5
      end
   end

   assign rx_ctl              = '{link_target_port_select, receiver_enable}; // RQ1 RQ2
   assign pin_input_enables   = input_enable;
   assign pin0_output_control = pin0_control;

endmodule

// *** verif/rpg_regs_monitor.sv ***
`timescale 1ns/1ps

// ==========================================================================
// Bus handshake and control output watcher for the register slice.
// ==========================================================================
module rpg_regs_monitor (
   // Clock and reset.
   input wire logic                    clock,
   input wire logic                    rst_n,
   // Bus handshakes.
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   // Control outputs.
   input wire rpg_pkg::rpg_rx_ctl_type rx_ctl,
   input wire logic [7:0]              pin_input_enables,
   input wire logic [7:0]              pin0_output_control
);
   import rpg_pkg::*;

   // All checks share the core clock and its reset.
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // A write taken whole in one cycle is answered two edges later.
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer not on time");
   // A taken read is answered at the next edge.
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not on time");
   // The write answer stands until it is taken.
   b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped early");
   // The read answer stands until it is taken.
   r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped early");
   // No new write is offered a slot while an answer is pending.
   w_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answer pending");
   // No new read is offered a slot while an answer is pending.
   r_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   // Upper read bits are zero, and a refused read returns zero.
   rd_clean_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
      && (s_axi_rresp != 2'h3 || s_axi_rdata == 32'h0000_0000)) else $error("dirty read");
   // Receivers and pin inputs come out of reset enabled.
   reset_values_a:
      assert property ($rose(rst_n) |-> rx_ctl == 8'h0F && pin_input_enables == 8'hFF)
      else $error("wrong values after reset");
   // Stored controls change only at the edge that completes a write.
   cfg_on_write_a:
      assert property ($changed(rx_ctl) || $changed(pin_input_enables)
      || $changed(pin0_output_control) |-> $rose(s_axi_bvalid))
      else $error("control changed without a write");
endmodule

bind rpg_regs rpg_regs_monitor mon_u (.clock(clock), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .rx_ctl(rx_ctl), .pin_input_enables(pin_input_enables),
   .pin0_output_control(pin0_output_control));

// *** verif/rpg_regs_tb.sv ***
`timescale 1ns/1ps

// ==========================================================================
// Self-checking bench for the register slice.
// ==========================================================================
module rpg_regs_tb;
   import rpg_pkg::*;

   // One ordinary case: address, byte written, byte read back, port value.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdat;
      logic [7:0] rexp;
      logic [7:0] pexp;
   } rpg_row_type;

   // Ordinary cases; the last one clears the supply override.
   localparam rpg_row_type row_table [0:7] = '{
      '{8'h30, 8'hA5, 8'hA5, 8'hA5}, '{8'h30, 8'h50, 8'h50, 8'h50},
      '{8'h3C, 8'h5A, 8'h5A, 8'h5A}, '{8'h40, 8'h3C, 8'h3C, 8'h3C},
      '{8'h34, 8'hF0, 8'hF9, 8'h07}, '{8'h34, 8'hC0, 8'hC9, 8'h04},
      '{8'h34, 8'h70, 8'h79, 8'h03}, '{8'h34, 8'h30, 8'h09, 8'h00}};
   // Read values expected after reset, one per register in address order.
   localparam logic [7:0] rst_table [0:4] = '{8'h0F, 8'h09, 8'h00, 8'hFF, 8'h00};

   logic           clock, rst_n, detect;   // Clock, reset, detected supply.
   logic [7:0]     awaddr, araddr, gpio;   // Addresses and pin levels.
   logic [31:0]    wdata, rdata, rd_word;  // Bus data and last read word.
   logic [3:0]     wstrb;                  // Write strobes.
   logic           awvalid, wvalid, bready, arvalid, rready;
   logic           awready, wready, bvalid, arready, rvalid;
   logic [1:0]     bresp, rresp, resp;     // Bus answers and last answer.
   rpg_rx_ctl_type rx_ctl;                 // Receiver controls out.
   rpg_io_supply_control_type io_supply_control;                 // Applied supply controls out.
   logic [7:0]     pin_en, pin0_ctl;       // Pin controls out.
   int             err_total, check_count; // Mismatch and comparison counts.

   rpg_regs dut_u (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .gpio_pin_level(gpio), .io_voltage_detect(detect),
      .rx_ctl(rx_ctl), .io_supply_control(io_supply_control), .pin_input_enables(pin_en),
      .pin0_output_control(pin0_ctl));

   // Free-running 50 MHz clock.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Prints the verdict and ends the run.
   task final_report;
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus write; the answer is accepted a cycle after it appears.
   task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready) && n < 40);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 40) begin
         err_total++;
         final_report();
      end
   endtask

   // One bus read; the answer is accepted a cycle after it appears.
   task rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && n < 40);
      rd_word = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 40) begin
         err_total++;
         final_report();
      end
   endtask

   // Control port that mirrors the register at an address.
   function automatic logic [7:0] port_of(input logic [7:0] a);
      case (a)
         8'h30:   port_of = rx_ctl;
         8'h34:   port_of = {5'h00, io_supply_control};
         8'h3C:   port_of = pin_en;
         default: port_of = pin0_ctl;
      endcase
   endfunction

   // Main sequence.
   initial begin
      {rst_n, detect, awaddr, araddr, gpio, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      err_total = 0;
      check_count = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      // Ordinary write and read-back cases.
      for (int i = 0; i < 8; i++) begin
         wr(row_table[i].addr, row_table[i].wdat, 4'hF);
         chk(resp, 2'h0);
         rd(row_table[i].addr);
         chk(resp, 2'h0);
         chk(rd_word, {24'h00_0000, row_table[i].rexp});
         chk(port_of(row_table[i].addr), row_table[i].pexp);
      end
      // Override clear: detection drives reads and the applied controls.
      detect <= 1'b1;
      repeat (5) @(posedge clock);
      rd(8'h34);
      chk(rd_word, 32'h0000_00B9);
      chk(io_supply_control, 3'h7);
      // Pin levels, masked inputs and an ignored write to the readback, answered OKAY.
      wr(8'h3C, 8'hFF, 4'hF);
      gpio <= 8'hA6;
      repeat (5) @(posedge clock);
      rd(8'h38);
      chk(rd_word, 32'h0000_00A6);
      wr(8'h3C, 8'h0F, 4'hF);
      rd(8'h38);
      chk(rd_word, 32'h0000_0006);
      wr(8'h38, 8'h00, 4'hF);
      chk(resp, 2'h0);
      rd(8'h38);
      chk(rd_word, 32'h0000_0006);
      // Unmapped and unaligned places, and a write with no strobe.
      wr(8'h44, 8'h55, 4'hF);
      chk(resp, 2'h3);
      rd(8'h31);
      chk(resp, 2'h3);
      chk(rd_word, 32'h0000_0000);
      wr(8'h40, 8'hFF, 4'h0);
      rd(8'h40);
      chk(rd_word, 32'h0000_003C);
      // Reset in mid-run restores every register.
      gpio <= 8'h00;
      detect <= 1'b0;
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk({rx_ctl, pin_en, pin0_ctl}, 32'h000F_FF00);
      for (int k = 0; k < 5; k++) begin
         rd(8'h30 + 8'(4 * k));
         chk(rd_word, {24'h00_0000, rst_table[k]});
      end
      final_report();
   end
endmodule
